//--- rtl/apc_capture.v
// Purpose: single-axis position capture on a selected trigger edge
// Assumes: all inputs synchronous to clk_i; one clock is one scan period
// Notes: axis number must be nonzero and below AXIS_COUNT
`include "apc_consts.vh"
module apc_capture
#(
    parameter POS_W = 32,
    parameter AXIS_W = 8,
    parameter AXIS_COUNT = 8'h20
)
(
    input wire clk_i,
    input wire arst_n_i,
    input wire start_i,
    input wire [AXIS_W-1:0] axis_i,
    input wire [3:0] trigger_sel_i,
    input wire [3:0] mode_i,
    input wire window_only_i,
    input wire [POS_W-1:0] window_start_i,
    input wire [POS_W-1:0] window_end_i,
    input wire [15:0] ctrl_inputs_i,
    input wire drive_capture_i,
    input wire drive_index_i,
    input wire [POS_W-1:0] encoder_count_i,
    input wire [POS_W-1:0] motor_count_i,
    input wire axis_alarm_i,
    input wire axis_offline_i,
    input wire takeover_i,
    output reg done_o,
    output reg busy_o,
    output reg active_o,
    output reg aborted_o,
    output reg error_o,
    output reg [15:0] fault_code_o,
    output reg [POS_W-1:0] latched_position_o,
    output reg [AXIS_W-1:0] axis_o
);
    reg start_d;
    reg [1:0] state;
    reg [1:0] next_state;
    reg [3:0] mode_q;
    reg [3:0] sel_q;
    reg hit;
    reg mode_ok;
    wire arm;
    wire sel_level;
    wire in_rise;
    wire in_fall;
    wire drv_rise;
    wire drv_fall;
    wire idx_rise;
    wire unused_window;
    wire [3:0] sel_now;

    // window capture not supported; inputs deliberately unread
    assign unused_window = window_only_i ^ window_start_i[0] ^ window_end_i[0];

    assign arm = start_i & ~start_d;
    // selector index 0..15 maps straight onto the packed input vector
    // history follows the new index from the arming edge on,
    // otherwise a change of index alone would look like a trigger edge
    assign sel_now = arm ? trigger_sel_i : sel_q;
    assign sel_level = ctrl_inputs_i[sel_now];

    // histories reset low, the idle level of every trigger input

    apc_edge u_sel_edge
    (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .level_i(sel_level),
        .rise_o(in_rise),
        .fall_o(in_fall)
    );

    apc_edge u_drv_edge
    (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .level_i(drive_capture_i),
        .rise_o(drv_rise),
        .fall_o(drv_fall)
    );

    apc_edge u_idx_edge
    (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .level_i(drive_index_i),
        .rise_o(idx_rise),
        .fall_o()
    );

    // modes outside the list are refused at arming
    always @*
    begin
        mode_ok = 1'b1;
        case (mode_i)
            `APC_MODE_IN_RISE, `APC_MODE_IN_FALL, `APC_MODE_DRV_RISE,
            `APC_MODE_DRV_FALL, `APC_MODE_DRV_BOTH, `APC_MODE_INDEX:
                mode_ok = 1'b1;
            default:
                mode_ok = 1'b0;
        endcase
    end

    always @*
    begin
        hit = 1'b0;
        case (mode_q)
            `APC_MODE_IN_RISE: hit = in_rise;
            `APC_MODE_IN_FALL: hit = in_fall;
            `APC_MODE_DRV_RISE: hit = drv_rise;
            `APC_MODE_DRV_FALL: hit = drv_fall;
            `APC_MODE_DRV_BOTH: hit = drv_rise | drv_fall;
            `APC_MODE_INDEX: hit = idx_rise;
            default: hit = 1'b0;
        endcase
    end

    // a refused arm is steered to END by the clocked process
    always @*
    begin
        next_state = state;
        case (state)
            `APC_ST_IDLE:
                if (arm)
                    next_state = `APC_ST_ARM;
            `APC_ST_ARM, `APC_ST_WAIT:
                if (axis_alarm_i | axis_offline_i | takeover_i | hit)
                    next_state = `APC_ST_END;
                else
                    next_state = `APC_ST_WAIT;
            `APC_ST_END:
                if (arm)
                    next_state = `APC_ST_ARM;
            default:
                next_state = `APC_ST_IDLE;
        endcase
    end

    always @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            start_d <= 1'b0;
            state <= `APC_ST_IDLE;
            mode_q <= `APC_MODE_IN_RISE;
            sel_q <= 4'h0;
            axis_o <= {AXIS_W{1'b0}};
            done_o <= 1'b0;
            busy_o <= 1'b0;
            active_o <= 1'b0;
            aborted_o <= 1'b0;
            error_o <= 1'b0;
            fault_code_o <= `APC_FAULT_NONE;
            latched_position_o <= {POS_W{1'b0}};
        end
        else
        begin
            start_d <= start_i;
            // flags from a finished run fall with the request
            if (!start_i)
            begin
                done_o <= 1'b0;
                error_o <= 1'b0;
                fault_code_o <= `APC_FAULT_NONE;
            end
            if (!start_i && !(state != `APC_ST_IDLE && state != `APC_ST_END && takeover_i))
                aborted_o <= 1'b0;
            if (arm && (axis_i == {AXIS_W{1'b0}} || axis_i >= AXIS_COUNT || !mode_ok))
            begin
                // illegal inputs refuse the arm outright
                // a refused re-arm must not leave the old run looking busy
                state <= `APC_ST_END;
                busy_o <= 1'b0;
                active_o <= 1'b0;
                error_o <= 1'b1;
                fault_code_o <= mode_ok ? `APC_FAULT_AXIS : `APC_FAULT_MODE;
                done_o <= 1'b0;
                aborted_o <= 1'b0;
            end
            else
            begin
                state <= next_state;
                if (arm)
                begin
                    axis_o <= axis_i;
                    mode_q <= mode_i;
                    sel_q <= trigger_sel_i;
                    busy_o <= 1'b1;
                    done_o <= 1'b0;
                    aborted_o <= 1'b0;
                    error_o <= 1'b0;
                    fault_code_o <= `APC_FAULT_NONE;
                end
                else if (state == `APC_ST_ARM || state == `APC_ST_WAIT)
                begin
                    // alarm and offline outrank takeover, which outranks a hit
                    active_o <= 1'b1;
                    if (axis_alarm_i | axis_offline_i)
                    begin
                        error_o <= 1'b1;
                        fault_code_o <= axis_alarm_i ? `APC_FAULT_ALARM : `APC_FAULT_OFFLINE;
                        busy_o <= 1'b0;
                        active_o <= 1'b0;
                    end
                    else if (takeover_i)
                    begin
                        aborted_o <= 1'b1;
                        busy_o <= 1'b0;
                        active_o <= 1'b0;
                    end
                    else if (hit)
                    begin
                        // first edge only; END ignores further edges
                        latched_position_o <= (mode_q == `APC_MODE_IN_RISE ||
                            mode_q == `APC_MODE_IN_FALL) ? encoder_count_i : motor_count_i;
                        done_o <= 1'b1;
                        busy_o <= 1'b0;
                        active_o <= 1'b0;
                    end
                end
            end
        end
    end
endmodule

//--- rtl/apc_consts.vh
// Purpose: constants for the axis position capture block
// Assumes: one 200 MHz clock, scan-cycle handshake on plain ports
// Notes: included by apc_capture only; the edge detector does not include it
// Functional notes
// - a capture is armed only on a false-to-true change of the start request, never by a held request.
// - the axis number is sampled at the arming edge and later changes are ignored until the next arm.
// - trigger selector codes 0-7 pick controller inputs 0-7 and codes 8-15 pick inputs 10-17.
// - the trigger selector matters only in modes 0 and 1; drive modes ignore it.
// - mode 0 latches the encoder count on a rising edge of the selected controller input.
// - mode 1 latches the encoder count on a falling edge of the selected controller input.
// - mode 5 latches the motor feedback count on a rising edge of the drive capture input.
// - mode 6 latches the motor feedback count on a falling edge of the drive capture input.
// - mode 7 latches the motor feedback count on either edge of the drive capture input.
// - mode 8 latches the motor feedback count on a rising edge of the drive index pulse.
// - a takeover raises aborted and drops busy and active; aborted clears with the request.
// - alarm, offline axis or illegal inputs raise error with a fault code until the request falls.
`ifndef APC_CONSTS_VH
`define APC_CONSTS_VH
`define APC_MODE_IN_RISE 4'h0
`define APC_MODE_IN_FALL 4'h1
`define APC_MODE_DRV_RISE 4'h5
`define APC_MODE_DRV_FALL 4'h6
`define APC_MODE_DRV_BOTH 4'h7
`define APC_MODE_INDEX 4'h8
`define APC_FAULT_NONE 16'h0000
`define APC_FAULT_ALARM 16'h0001
`define APC_FAULT_OFFLINE 16'h0002
`define APC_FAULT_MODE 16'h0003
`define APC_FAULT_AXIS 16'h0004
`define APC_ST_IDLE 2'h0
`define APC_ST_ARM 2'h1
`define APC_ST_WAIT 2'h2
`define APC_ST_END 2'h3
`endif

//--- rtl/apc_edge.v
// Purpose: rise and fall detection of one synchronous level
// Assumes: input already synchronous to clk_i
// Notes: history resets low, so a high input gives a rise on the first cycle
module apc_edge
(
    input wire clk_i,
    input wire arst_n_i,
    input wire level_i,
    output wire rise_o,
    output wire fall_o
);
    reg prev;

    always @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            prev <= 1'b0;
        else
            prev <= level_i;
    end

    assign rise_o = level_i & ~prev;
    assign fall_o = ~level_i & prev;
endmodule

//--- verif/apc_drive_model.sv
// Purpose: drive and encoder side model
// Assumes: commands change at the falling edge
// Notes: index mark lasts one cycle, as a real one
module apc_drive_model
(
    input wire clk_i,
    input wire arst_n_i,
    input wire [1:0] cmd_i,
    input wire [31:0] count_i,
    output reg drive_capture_o,
    output reg drive_index_o,
    output reg [31:0] motor_count_o
);
    timeunit 1ns;
    timeprecision 1ps;
    always @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            drive_capture_o <= 1'h0;
            drive_index_o <= 1'h0;
            motor_count_o <= 32'h0;
        end
        else
        begin
            drive_capture_o <= drive_capture_o ^ cmd_i[0];
            drive_index_o <= cmd_i[1];
            motor_count_o <= count_i;
        end
    end
endmodule

//--- verif/apc_capture_assertions.sv
// Purpose: handshake checks
// Assumes: one clock domain
// Notes: watches a subset of ports
module apc_capture_assertions
(
    input wire clk_i,
    input wire arst_n_i,
    input wire start_i,
    input wire done_o,
    input wire busy_o,
    input wire active_o,
    input wire aborted_o,
    input wire error_o,
    input wire [15:0] fault_code_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    arm_busy_a: assert property ($rose(start_i) |=> busy_o || error_o || aborted_o)
        else $error("no busy after arm");
    busy_cause_a: assert property ($rose(busy_o) |-> $past(start_i) && !$past(start_i, 2))
        else $error("busy without arm");
    active_lag_a: assert property ($rose(busy_o) |=> active_o || !busy_o)
        else $error("active late");
    active_busy_a: assert property (active_o |-> busy_o)
        else $error("active without busy");
    done_drop_a: assert property (done_o |-> !busy_o && !active_o)
        else $error("busy with done");
    done_hold_a: assert property (done_o && start_i |=> done_o)
        else $error("done lost");
    done_clear_a: assert property (done_o && !start_i |=> !done_o)
        else $error("done stuck");
    abort_drop_a: assert property (aborted_o |-> !busy_o && !active_o)
        else $error("busy with abort");
    abort_clear_a: assert property (aborted_o && !start_i |=> !aborted_o)
        else $error("abort stuck");
    error_code_a: assert property (error_o == (fault_code_o != 16'h0000))
        else $error("code mismatch");
    error_clear_a: assert property (error_o && !start_i |=> !error_o)
        else $error("error stuck");
    cover property ($rose(done_o));
    cover property ($rose(error_o));
    cover property ($rose(aborted_o));
endmodule
bind apc_capture apc_capture_assertions u_chk
(
    .clk_i(clk_i), .arst_n_i(arst_n_i), .start_i(start_i), .done_o(done_o),
    .busy_o(busy_o), .active_o(active_o), .aborted_o(aborted_o),
    .error_o(error_o), .fault_code_o(fault_code_o)
);

//--- verif/axis_position_capture_tb_top.sv
// Purpose: self-checking bench
// Assumes: inputs change at the falling edge
// Notes: a monitor checks latched values in queue order
module axis_position_capture_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    reg clk_i = 1'h0;
    reg arst_n_i = 1'h0;
    reg start_i = 1'h0, alarm = 1'h0, offl = 1'h0, tko = 1'h0, last_done = 1'h0;
    reg [1:0] cmd = 2'h0;
    reg [3:0] sel = 4'h0, mode = 4'h0;
    reg [7:0] axis = 8'h01, ax_exp;
    reg [15:0] ins = 16'h0, b;
    reg [31:0] lf = 32'h3AA4, enc = 32'h0, mc = 32'h0, exp_pos;
    wire cap_w, idx_w, done_o, busy_o, active_o, aborted_o, error_o;
    wire [7:0] axis_o;
    wire [15:0] fault_code_o;
    wire [31:0] mot_w, latched_position_o;
    integer failures = 0, checks_done = 0, i;
    reg [31:0] q [$];
    apc_capture u_apc_capture
    (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .start_i(start_i), .axis_i(axis),
        .trigger_sel_i(sel), .mode_i(mode), .window_only_i(lf[9]),
        .window_start_i(lf), .window_end_i(~lf), .ctrl_inputs_i(ins),
        .drive_capture_i(cap_w), .drive_index_i(idx_w), .encoder_count_i(enc),
        .motor_count_i(mot_w), .axis_alarm_i(alarm), .axis_offline_i(offl),
        .takeover_i(tko), .done_o(done_o), .busy_o(busy_o), .active_o(active_o),
        .aborted_o(aborted_o), .error_o(error_o), .fault_code_o(fault_code_o),
        .latched_position_o(latched_position_o), .axis_o(axis_o)
    );
    apc_drive_model u_apc_drive_model
    (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .cmd_i(cmd), .count_i(mc),
        .drive_capture_o(cap_w), .drive_index_o(idx_w), .motor_count_o(mot_w)
    );
    initial forever #2.5 clk_i = ~clk_i;
    function [31:0] nxt(input [31:0] v);
        nxt = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task chk(input ok, input [8*8-1:0] s);
        begin
            checks_done = checks_done + 1;
            if (ok !== 1'b1)
            begin
                failures = failures + 1;
                $display("unexpected at %0t: %0s", $time, s);
            end
        end
    endtask
    task complete_run;
        begin
            $display("checks %0d failures %0d", checks_done, failures);
            if (failures == 0 && checks_done > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    // bounded wait for any end of a capture
    task settle;
        integer n;
        begin
            n = 0;
            while (n < 20 && (done_o | error_o | aborted_o) !== 1'b1)
            begin
                @(negedge clk_i);
                n = n + 1;
            end
            if ((done_o | error_o | aborted_o) !== 1'b1)
            begin
                chk(1'b0, "timeout");
                complete_run;
            end
        end
    endtask
    task cap(input [3:0] m);
        begin
            lf = nxt(lf);
            sel = lf[3:0];
            b = 16'h0001 << lf[3:0];
            mode = m;
            axis = lf[11:4] % 8'h1F + 8'h01;
            ax_exp = axis;
            ins = (m == 4'h1) ? 16'hFFFF : 16'h0000;
            enc = lf;
            mc = ~lf;
            exp_pos = (m < 4'h5) ? lf : ~lf;
            cmd = {1'b0, (m == 4'h5 && cap_w) || (m == 4'h6 && !cap_w)};
            @(negedge clk_i);
            cmd = 2'h0;
            start_i = 1'h1;
            q.push_back(exp_pos);
            @(negedge clk_i);
            axis = 8'h00;
            @(negedge clk_i);
            ins = ins ^ ((m < 4'h5) ? ~b : 16'hFFFF);
            repeat (3) @(negedge clk_i);
            chk(done_o === 1'b0 && busy_o === 1'b1 && active_o === 1'b1, "early");
            if (m < 4'h5)
                ins = ins ^ b;
            else
                cmd = {m == 4'h8, m != 4'h8};
            @(negedge clk_i);
            cmd = 2'h0;
            settle;
            ins = ~ins;
            enc = ~enc;
            mc = lf;
            cmd = 2'h3;
            @(negedge clk_i);
            cmd = 2'h0;
            repeat (3) @(negedge clk_i);
            chk(latched_position_o === exp_pos && done_o === 1'b1, "held");
            chk(axis_o === ax_exp, "axis");
            start_i = 1'h0;
            repeat (2) @(negedge clk_i);
            $display("capture mode %0d ends", m);
        end
    endtask
    task flt(input integer k);
        begin
            axis = (k == 0) ? 8'h00 : 8'h03;
            mode = (k == 1) ? 4'h2 : 4'h5;
            start_i = 1'h1;
            @(negedge clk_i);
            alarm = (k == 2);
            offl = (k == 3);
            tko = (k == 4);
            settle;
            if (k < 4)
                chk(error_o === 1'b1 &&
                    fault_code_o === 16'(64'h4000300010002 >> (48 - 16 * k)), "fault");
            else
                chk(aborted_o === 1'b1 && busy_o === 1'b0, "abort");
            start_i = 1'h0;
            {alarm, offl, tko} = 3'h0;
            repeat (2) @(negedge clk_i);
            chk((error_o | aborted_o) === 1'b0, "clear");
            $display("fault case %0d ends", k);
        end
    endtask
    always @(negedge clk_i)
    begin
        if (done_o === 1'b1 && !last_done)
            chk(q.size() > 0 && latched_position_o === q.pop_front(), "position");
        last_done <= done_o === 1'b1;
    end
    initial
    begin
        repeat (16) @(negedge clk_i);
        arst_n_i = 1'h1;
        for (i = 0; i < 12; i = i + 1)
            cap(4'(24'h015678 >> (20 - 4 * (i % 6))));
        for (i = 0; i < 5; i = i + 1)
            flt(i);
        complete_run;
    end
endmodule
